// ==== rtl/pmsc_pkg.sv ====
// constants and types for the pattern match slice configuration block
package pmsc_pkg;

  // ==========================================================
  // geometry
  localparam int unsigned NUM_SLICES = 8;
  localparam int unsigned FIELD_W = 3;
  localparam int unsigned DATA_W = 32;

  // ==========================================================
  // register byte addresses
  localparam logic [31:0] ADDR_CONTROL = 32'ha000_4000;
  localparam logic [31:0] ADDR_SOURCE = 32'ha000_402c;
  localparam logic [31:0] ADDR_CONFIG = 32'ha000_4030;
  localparam logic [31:0] ADDR_INT_STATUS = 32'ha000_4040;
  localparam logic [31:0] ADDR_INT_MASK = 32'ha000_4044;

  // ==========================================================
  // field positions
  localparam int unsigned ENDPOINT_LSB = 0;
  localparam int unsigned RESERVED_BIT = 7;
  localparam int unsigned COND_LSB = 8;
  localparam int unsigned SRC_LSB = 8;
  localparam int unsigned CTRL_PMODE_BIT = 0;
  localparam int unsigned CTRL_EVENT_BIT = 1;

  // ==========================================================
  // reset values and config write mask
  localparam logic [31:0] RST_CONTROL = 32'h0000_0000;
  localparam logic [31:0] RST_SOURCE = 32'h0000_0000;
  localparam logic [31:0] RST_CONFIG = 32'h0000_0000;
  localparam logic [7:0] RST_INT = 8'h00;
  localparam logic [31:0] CONFIG_WMASK = 32'hffff_ff7f;

  // ==========================================================
  // slice match conditions
  typedef enum logic [2:0] {
    COND_TRUE = 3'h0,
    COND_STICKY_RISE = 3'h1,
    COND_STICKY_FALL = 3'h2,
    COND_STICKY_BOTH = 3'h3,
    COND_HIGH = 3'h4,
    COND_LOW = 3'h5,
    COND_FALSE = 3'h6,
    COND_EVENT = 3'h7
  } pmsc_cond_type;

  // ==========================================================
  // register port request
  typedef struct packed {
    logic wr;
    logic rd;
    logic [31:0] addr;
    logic [31:0] wdata;
  } pmsc_bus_req_type;

endpackage : pmsc_pkg

// ==== rtl/pmsc_top.sv ====
// pattern match slice configuration, detect logic and pin interrupts
//
// Our own choice: the strobed register port.
`timescale 1ns/10ps

// Operation
// - each slice picks one of eight match conditions set by software
// - config bits 0 to 6 mark the slice with that index as term end
// - sticky edge conditions hold the slice output high until next clear
// - event condition gives a one-cycle high per rising or falling edge
// - any write to config or source register clears all edge history
// - clearing both control enable bits disables engine and clears history
// - an endpoint slice raises its interrupt while its product term is true
// - slice after an endpoint starts a new term, terms joined by OR
// - cleared endpoint bit continues the term; endpoint bits reset to zero
// - endpoint slice n, n from 0 to 7, drives pin interrupt line n
// - config bit 7 reads zero; slice 7 always ends a product term
// - 3-bit condition fields from bits 10:8 upward with fixed encoding
// - 3-bit source fields pick one of eight pins; slice 7 at 31:29
module pmsc_top (
  // clock and reset
  input wire logic i_ref_clk,
  input wire logic i_rst_b,
  // register port
  input wire pmsc_pkg::pmsc_bus_req_type i_bus,
  output logic [31:0] o_rdata,
  // selected pins
  input wire logic [7:0] i_pin,
  // interrupt outputs
  output logic [7:0] o_pin_int,
  output logic o_match_event,
  output logic o_irq
);

  // ==========================================================
  // registers
  logic [31:0] control_q, control_d;
  logic [31:0] source_q, source_d;
  logic [31:0] config_q, config_d;
  logic [7:0] int_status_q, int_status_d;
  logic [7:0] int_mask_q, int_mask_d;
  logic [31:0] rdata_q, rdata_d;
  logic [7:0] pin_q, pin_d;
  logic [7:0] prev_q, prev_d;
  logic [7:0] rise_hist_q, rise_hist_d;
  logic [7:0] fall_hist_q, fall_hist_d;
  logic [7:0] pin_int_q, pin_int_d;
  logic match_q, match_d;

  // ==========================================================
  // combinational terms
  logic engine_en;
  logic hist_clr;
  logic [7:0] endpoint;
  logic [7:0] rise_now;
  logic [7:0] fall_now;
  logic [7:0] level_now;
  logic [7:0] contrib;
  logic [7:0] term;
  logic term_acc;
  pmsc_pkg::pmsc_cond_type cond [8];
  logic [2:0] src [8];

  // ==========================================================
  // engine enable and history clear
  always_comb begin
    engine_en = control_q[pmsc_pkg::CTRL_PMODE_BIT] | control_q[pmsc_pkg::CTRL_EVENT_BIT];
    hist_clr = !engine_en;
    if (i_bus.wr && (i_bus.addr == pmsc_pkg::ADDR_CONFIG ||
        i_bus.addr == pmsc_pkg::ADDR_SOURCE)) begin
      hist_clr = 1'b1;
    end
  end

  // ==========================================================
  // per-slice input selection and edges
  always_comb begin
    pin_d = i_pin;
    prev_d = pin_q;
    for (int i = 0; i < pmsc_pkg::NUM_SLICES; i++) begin
      cond[i] = pmsc_pkg::pmsc_cond_type'(config_q[pmsc_pkg::COND_LSB + i * 3 +: 3]);
      src[i] = source_q[pmsc_pkg::SRC_LSB + i * 3 +: 3];
      level_now[i] = pin_q[src[i]];
      rise_now[i] = pin_q[src[i]] & !prev_q[src[i]];
      fall_now[i] = !pin_q[src[i]] & prev_q[src[i]];
    end
  end

  // ==========================================================
  // sticky edge history, a new edge wins over a clear
  always_comb begin
    if (hist_clr) begin
      rise_hist_d = rise_now;
      fall_hist_d = fall_now;
    end else begin
      rise_hist_d = rise_hist_q | rise_now;
      fall_hist_d = fall_hist_q | fall_now;
    end
  end

  // ==========================================================
  // slice contributions
  always_comb begin
    for (int i = 0; i < pmsc_pkg::NUM_SLICES; i++) begin
      case (cond[i])
        pmsc_pkg::COND_TRUE: contrib[i] = 1'b1;
        pmsc_pkg::COND_STICKY_RISE: contrib[i] = rise_hist_q[i];
        pmsc_pkg::COND_STICKY_FALL: contrib[i] = fall_hist_q[i];
        pmsc_pkg::COND_STICKY_BOTH: contrib[i] = rise_hist_q[i] | fall_hist_q[i];
        pmsc_pkg::COND_HIGH: contrib[i] = level_now[i];
        pmsc_pkg::COND_LOW: contrib[i] = !level_now[i];
        pmsc_pkg::COND_FALSE: contrib[i] = 1'b0;
        pmsc_pkg::COND_EVENT: contrib[i] = rise_now[i] | fall_now[i];
        default: contrib[i] = 1'b0;
      endcase
    end
  end

  // ==========================================================
  // product terms and match
  always_comb begin
    endpoint = {1'b1, config_q[6:0]};
    term_acc = 1'b1;
    for (int i = 0; i < pmsc_pkg::NUM_SLICES; i++) begin
      term_acc = term_acc & contrib[i];
      term[i] = term_acc & endpoint[i];
      if (endpoint[i]) begin
        term_acc = 1'b1;
      end
    end
    pin_int_d = engine_en ? term : 8'h00;
    match_d = control_q[pmsc_pkg::CTRL_EVENT_BIT] & (|term);
  end

  // ==========================================================
  // register writes, status and read data
  always_comb begin
    control_d = control_q;
    source_d = source_q;
    config_d = config_q;
    int_mask_d = int_mask_q;
    int_status_d = int_status_q;
    rdata_d = 32'h0000_0000;
    if (i_bus.wr) begin
      case (i_bus.addr)
        pmsc_pkg::ADDR_CONTROL: control_d = {30'h0000_0000, i_bus.wdata[1:0]};
        pmsc_pkg::ADDR_SOURCE: source_d = {i_bus.wdata[31:8], 8'h00};
        pmsc_pkg::ADDR_CONFIG: config_d = i_bus.wdata & pmsc_pkg::CONFIG_WMASK;
        pmsc_pkg::ADDR_INT_STATUS: int_status_d = int_status_q & ~i_bus.wdata[7:0];
        pmsc_pkg::ADDR_INT_MASK: int_mask_d = i_bus.wdata[7:0];
        default: ;
      endcase
    end
    int_status_d = int_status_d | pin_int_d;
    if (i_bus.rd) begin
      case (i_bus.addr)
        pmsc_pkg::ADDR_CONTROL: rdata_d = control_q;
        pmsc_pkg::ADDR_SOURCE: rdata_d = source_q;
        pmsc_pkg::ADDR_CONFIG: rdata_d = config_q;
        pmsc_pkg::ADDR_INT_STATUS: rdata_d = {24'h00_0000, int_status_q};
        pmsc_pkg::ADDR_INT_MASK: rdata_d = {24'h00_0000, int_mask_q};
        default: rdata_d = 32'h0000_0000;
      endcase
    end
  end

  // ==========================================================
  // state registers
  always_ff @(posedge i_ref_clk) begin
    if (!i_rst_b) begin
      control_q <= pmsc_pkg::RST_CONTROL;
      source_q <= pmsc_pkg::RST_SOURCE;
      config_q <= pmsc_pkg::RST_CONFIG;
      int_status_q <= pmsc_pkg::RST_INT;
      int_mask_q <= pmsc_pkg::RST_INT;
      rdata_q <= 32'h0000_0000;
      pin_q <= 8'h00;
      prev_q <= 8'h00;
      rise_hist_q <= 8'h00;
      fall_hist_q <= 8'h00;
      pin_int_q <= 8'h00;
      match_q <= 1'b0;
    end else begin
      control_q <= control_d;
      source_q <= source_d;
      config_q <= config_d;
      int_status_q <= int_status_d;
      int_mask_q <= int_mask_d;
      rdata_q <= rdata_d;
      pin_q <= pin_d;
      prev_q <= prev_d;
      rise_hist_q <= rise_hist_d;
      fall_hist_q <= fall_hist_d;
      pin_int_q <= pin_int_d;
      match_q <= match_d;
    end
  end

  // ==========================================================
  // outputs
  assign o_rdata = rdata_q;
  assign o_pin_int = pin_int_q;
  assign o_match_event = match_q;
  assign o_irq = |(int_status_q & int_mask_q);

  // ==========================================================
  // checks
  property p_sticky_holds;
    @(posedge i_ref_clk) disable iff (!i_rst_b)
    (cond[0] == pmsc_pkg::COND_STICKY_BOTH && contrib[0] && !hist_clr) |=> contrib[0];
  endproperty
  a_sticky_holds: assert property (p_sticky_holds)
    else $error("sticky slice output dropped without clear");

  property p_event_one_cycle;
    @(posedge i_ref_clk) disable iff (!i_rst_b)
    (cond[0] == pmsc_pkg::COND_EVENT && contrib[0] && !i_bus.wr && i_pin == pin_q)
      |=> !contrib[0];
  endproperty
  a_event_one_cycle: assert property (p_event_one_cycle)
    else $error("event slice output lasted more than one cycle");

  property p_event_path;
    @(posedge i_ref_clk) disable iff (!i_rst_b)
    (engine_en && config_q[0] && cond[0] == pmsc_pkg::COND_EVENT && src[0] == 3'h0 &&
     $rose(i_pin[0]) && !i_bus.wr) ##1 !i_bus.wr |=> o_pin_int[0];
  endproperty
  a_event_path: assert property (p_event_path)
    else $error("pin edge did not reach interrupt line 0 in two cycles");

  property p_write_clears;
    @(posedge i_ref_clk) disable iff (!i_rst_b)
    (i_bus.wr && i_bus.addr == pmsc_pkg::ADDR_SOURCE)
      |=> (rise_hist_q == $past(rise_now) && fall_hist_q == $past(fall_now));
  endproperty
  a_write_clears: assert property (p_write_clears)
    else $error("source write did not clear edge history");

  property p_disable;
    @(posedge i_ref_clk) disable iff (!i_rst_b)
    !engine_en |=> (o_pin_int == 8'h00);
  endproperty
  a_disable: assert property (p_disable)
    else $error("pin interrupt while engine disabled");

  property p_reserved_zero;
    @(posedge i_ref_clk) disable iff (!i_rst_b)
    (i_bus.rd && i_bus.addr == pmsc_pkg::ADDR_CONFIG) |=> !o_rdata[pmsc_pkg::RESERVED_BIT];
  endproperty
  a_reserved_zero: assert property (p_reserved_zero)
    else $error("reserved config bit read as one");

  property p_slice7_end;
    @(posedge i_ref_clk) disable iff (!i_rst_b)
    (engine_en && contrib == 8'hff && config_q[6:0] == 7'h00) |=> (o_pin_int == 8'h80);
  endproperty
  a_slice7_end: assert property (p_slice7_end)
    else $error("slice 7 did not act as the only endpoint");

  property p_new_term;
    @(posedge i_ref_clk) disable iff (!i_rst_b)
    (engine_en && config_q[0] && config_q[6:1] == 6'h00 && contrib[7:1] == 7'h7f)
      |=> o_pin_int[7];
  endproperty
  a_new_term: assert property (p_new_term)
    else $error("term after endpoint depended on earlier slice");

  property p_continue_term;
    @(posedge i_ref_clk) disable iff (!i_rst_b)
    (config_q[6:0] == 7'h00 && !contrib[0]) |=> !o_pin_int[7];
  endproperty
  a_continue_term: assert property (p_continue_term)
    else $error("cleared endpoint bit broke the product term");

  property p_irq_status;
    @(posedge i_ref_clk) disable iff (!i_rst_b)
    (engine_en && (term & int_mask_q) != 8'h00 && !i_bus.wr) |=> o_irq;
  endproperty
  a_irq_status: assert property (p_irq_status)
    else $error("unmasked term match did not raise the interrupt");

  property p_level_path;
    @(posedge i_ref_clk) disable iff (!i_rst_b)
    (engine_en && config_q[0] && cond[0] == pmsc_pkg::COND_HIGH)
      |=> (o_pin_int[0] == $past(level_now[0]));
  endproperty
  a_level_path: assert property (p_level_path)
    else $error("level slice did not follow its selected input");

  property p_match_gate;
    @(posedge i_ref_clk) disable iff (!i_rst_b)
    (control_q[pmsc_pkg::CTRL_EVENT_BIT] && term != 8'h00) |=> o_match_event;
  endproperty
  a_match_gate: assert property (p_match_gate)
    else $error("true product term did not raise the match event");

  property p_rdata_idle;
    @(posedge i_ref_clk) disable iff (!i_rst_b)
    !i_bus.rd |=> (o_rdata == 32'h0000_0000);
  endproperty
  a_rdata_idle: assert property (p_rdata_idle)
    else $error("read data not zero outside a read");

endmodule : pmsc_top

// ==== tb/pmsc_intc_model.sv ====
// interrupt controller model that latches each pin interrupt line until acknowledged
`timescale 1ns/10ps
module pmsc_intc_model (
  // clock and reset
  input wire logic i_ref_clk,
  input wire logic i_rst_b,
  // pin interrupt lines and acknowledge
  input wire logic [7:0] i_pin_int,
  input wire logic [7:0] i_ack,
  // pending lines
  output logic [7:0] o_pending
);
  logic [7:0] pend_d;
  logic [7:0] pend_q;
  always_comb begin
    pend_d = (pend_q & ~i_ack) | i_pin_int;
  end
  always_ff @(posedge i_ref_clk) begin
    if (!i_rst_b) begin
      pend_q <= 8'h00;
    end else begin
      pend_q <= pend_d;
    end
  end
  assign o_pending = pend_q;
endmodule : pmsc_intc_model

// ==== tb/pmsc_top_test.sv ====
// self-checking bench for the pattern match slice block
`timescale 1ns/10ps
module pmsc_top_test;
  // ==========================================================
  // signals
  localparam logic [31:0] ALLF = 32'hdb6d_b600;
  logic clk = 1'b0;
  logic rst_b = 1'b0;
  pmsc_pkg::pmsc_bus_req_type bus = '0;
  logic [7:0] pin = 8'h00;
  logic [7:0] ack = 8'h00;
  logic [31:0] rdata;
  logic [7:0] pint;
  logic [7:0] pend;
  logic mev;
  logic irq;
  logic [3:0] hc;
  int n_errors = 0;
  int n_compared = 0;
  int cycles = 0;

  always #10 clk = ~clk;

  pmsc_top dut (.i_ref_clk(clk), .i_rst_b(rst_b), .i_bus(bus), .o_rdata(rdata),
    .i_pin(pin), .o_pin_int(pint), .o_match_event(mev), .o_irq(irq));
  pmsc_intc_model intc (.i_ref_clk(clk), .i_rst_b(rst_b), .i_pin_int(pint),
    .i_ack(ack), .o_pending(pend));

  // ==========================================================
  // tasks
  function automatic logic [31:0] fs(logic [31:0] b, int s, logic [2:0] c);
    return (b & ~(32'h0000_0007 << (8 + 3 * s))) | ({29'h0, c} << (8 + 3 * s));
  endfunction : fs
  task automatic conclude();
    $display("compared %0d, errors %0d", n_compared, n_errors);
    if (n_errors == 0 && n_compared > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask : conclude
  task automatic chk(logic [31:0] seen, logic [31:0] exp);
    n_compared++;
    if (seen !== exp) begin
      n_errors++;
      $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask : chk
  task automatic wr(logic [31:0] a, logic [31:0] d);
    @(posedge clk);
    bus <= '{1'b1, 1'b0, a, d};
    @(posedge clk);
    bus <= '0;
  endtask : wr
  task automatic rd(logic [31:0] a, logic [31:0] exp);
    @(posedge clk);
    bus <= '{1'b0, 1'b1, a, 32'h0000_0000};
    @(posedge clk);
    bus <= '0;
    #1;
    chk(rdata, exp);
  endtask : rd
  task automatic settle(logic [7:0] e);
    repeat (4) @(posedge clk);
    #1;
    chk({24'h0, pint}, {24'h0, e});
  endtask : settle
  task automatic pc(logic [7:0] p, logic [7:0] e);
    @(posedge clk);
    pin <= p;
    settle(e);
  endtask : pc
  task automatic t0(logic [2:0] c, logic p0, logic p1, logic e);
    @(posedge clk);
    pin <= {7'h0, p0};
    repeat (3) @(posedge clk);
    wr(pmsc_pkg::ADDR_CONFIG, fs(ALLF, 0, c) | 32'h0000_0001);
    pc({7'h0, p1}, {7'h0, e});
  endtask : t0

  // ==========================================================
  // timeout
  always @(posedge clk) begin
    cycles <= cycles + 1;
    if (cycles == 4000) begin
      n_errors++;
      conclude();
    end
  end

  // ==========================================================
  // tests
  initial begin
    repeat (4) @(posedge clk);
    rst_b <= 1'b1;
    rd(pmsc_pkg::ADDR_CONFIG, 32'h0000_0000);
    rd(pmsc_pkg::ADDR_SOURCE, 32'h0000_0000);
    wr(pmsc_pkg::ADDR_CONFIG, 32'hffff_ffff);
    rd(pmsc_pkg::ADDR_CONFIG, 32'hffff_ff7f);
    wr(pmsc_pkg::ADDR_SOURCE, 32'he000_0000);
    rd(pmsc_pkg::ADDR_SOURCE, 32'he000_0000);
    rd(32'ha000_4050, 32'h0000_0000);
    // all slices constant true, no endpoint bits: only the last term
    wr(pmsc_pkg::ADDR_CONFIG, 32'h0000_0000);
    wr(pmsc_pkg::ADDR_CONTROL, 32'h0000_0001);
    settle(8'h80);
    wr(pmsc_pkg::ADDR_CONFIG, fs(32'h0, 7, pmsc_pkg::COND_HIGH));
    pc(8'h80, 8'h80);
    pc(8'h7f, 8'h00);
    // every condition on slice 0
    t0(pmsc_pkg::COND_TRUE, 1'b0, 1'b0, 1'b1);
    t0(pmsc_pkg::COND_STICKY_RISE, 1'b1, 1'b0, 1'b0);
    t0(pmsc_pkg::COND_STICKY_FALL, 1'b0, 1'b1, 1'b0);
    t0(pmsc_pkg::COND_STICKY_FALL, 1'b1, 1'b0, 1'b1);
    t0(pmsc_pkg::COND_STICKY_BOTH, 1'b1, 1'b0, 1'b1);
    t0(pmsc_pkg::COND_HIGH, 1'b0, 1'b1, 1'b1);
    t0(pmsc_pkg::COND_LOW, 1'b0, 1'b1, 1'b0);
    t0(pmsc_pkg::COND_FALSE, 1'b0, 1'b1, 1'b0);
    t0(pmsc_pkg::COND_EVENT, 1'b0, 1'b1, 1'b0);
    t0(pmsc_pkg::COND_STICKY_RISE, 1'b0, 1'b1, 1'b1);
    pc(8'h00, 8'h01);
    // history cleared by a source write and by disabling
    wr(pmsc_pkg::ADDR_SOURCE, 32'h0000_0000);
    settle(8'h00);
    pc(8'h01, 8'h01);
    wr(pmsc_pkg::ADDR_CONTROL, 32'h0000_0000);
    wr(pmsc_pkg::ADDR_CONTROL, 32'h0000_0001);
    settle(8'h00);
    // event lasts exactly one cycle
    t0(pmsc_pkg::COND_EVENT, 1'b0, 1'b0, 1'b0);
    @(posedge clk);
    pin <= 8'h01;
    hc = 4'h0;
    repeat (6) begin
      @(posedge clk);
      #1;
      hc = hc + {3'h0, pint[0]};
    end
    chk({28'h0, hc}, 32'h0000_0001);
    // status, mask and level interrupt
    wr(pmsc_pkg::ADDR_INT_MASK, 32'h0000_0000);
    wr(pmsc_pkg::ADDR_INT_STATUS, 32'h0000_00ff);
    t0(pmsc_pkg::COND_HIGH, 1'b0, 1'b1, 1'b1);
    rd(pmsc_pkg::ADDR_INT_STATUS, 32'h0000_0001);
    chk({31'h0, irq}, 32'h0000_0000);
    wr(pmsc_pkg::ADDR_INT_MASK, 32'h0000_0001);
    #1;
    chk({31'h0, irq}, 32'h0000_0001);
    pc(8'h00, 8'h00);
    wr(pmsc_pkg::ADDR_INT_STATUS, 32'h0000_0001);
    rd(pmsc_pkg::ADDR_INT_STATUS, 32'h0000_0000);
    chk({31'h0, irq}, 32'h0000_0000);
    // two terms split by endpoints at slices 1 and 2
    wr(pmsc_pkg::ADDR_SOURCE, fs(fs(32'h0, 1, 3'h1), 2, 3'h2));
    wr(pmsc_pkg::ADDR_CONFIG, fs(fs(fs(ALLF, 0, pmsc_pkg::COND_HIGH), 1,
      pmsc_pkg::COND_HIGH), 2, pmsc_pkg::COND_HIGH) | 32'h0000_0006);
    pc(8'h00, 8'h00);
    @(posedge clk);
    ack <= 8'hff;
    @(posedge clk);
    ack <= 8'h00;
    pc(8'h01, 8'h00);
    pc(8'h03, 8'h02);
    pc(8'h04, 8'h04);
    pc(8'h07, 8'h06);
    chk({24'h0, pend}, 32'h0000_0006);
    chk({31'h0, mev}, 32'h0000_0000);
    // event output enable alone keeps the engine on and drives the match
    wr(pmsc_pkg::ADDR_CONTROL, 32'h0000_0002);
    repeat (2) @(posedge clk);
    #1;
    chk({31'h0, mev}, 32'h0000_0001);
    chk({24'h0, pint}, 32'h0000_0006);
    conclude();
  end
endmodule : pmsc_top_test
